/* File: src/boot_port_device.sv */
// device end: serial boot command interpreter in front of the flash array
// Contract
// - boot area is one 8 Kbyte erase block
// - serial mode never rewrites the boot area; code still runs erase all and lock program there
// - mode entry: cs high, enable low, mode high
// - programmer feeds 20 oscillator cycles during reset; the bench rst task holds reset low for 16 clock cycles
// - link uses clock, receive, transmit, busy only
// - programmer makes the transfer clock
// - busy low when ready, high when reception starts
// - receive bits sampled on transfer clock rise
// - transmit bits launched on transfer clock fall
// - 8-bit units, least significant bit first
// - busy high while shifting or flash working
// - programmer waits for busy low per byte
// - 7-byte ID mismatch on programmed flash rejects commands
// - before ID check only status read accepted; code also accepts the ID check command F5
// - read FF, two address bytes, data to 259
// - program 41, two address bytes, data to 259
// - erase 20+addr+D0, erase all A7+D0
// - lock read 71, address, lock in fourth byte
// - primary status resets to 80 hex
// - clear status 50 clears bits 3-5, busy low
`timescale 1ns/1ns
`include "fsb_consts.svh"
module boot_port_device
	import fsb_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	boot_link_if.device      link,
	input  wire logic        chip_select_strap,
	input  wire logic        program_enable_strap,
	input  wire logic        processor_mode_strap,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_lock,
	input  wire logic        mem_fail,
	input  wire logic        mem_overwrite,
	input  wire logic        mem_blank,
	input  wire logic [55:0] stored_id,
	output logic             serial_mode,
	output logic             mem_req,
	output mem_op_t          mem_op,
	output logic [15:0]      mem_page,
	output logic [7:0]       mem_index,
	output logic [7:0]       mem_wdata,
	output logic             mem_unlock_all
);
	dev_state_t  state, next_state;
	logic [2:0]  strap_s1, strap_s2;
	logic [2:0]  settle, next_settle;
	logic        next_serial_mode;
	logic        busy, next_busy;
	logic [7:0]  cmd, next_cmd;
	logic [8:0]  idx, next_idx;
	logic [8:0]  byte_no;
	logic [7:0]  addr_mid, next_addr_mid;
	logic [7:0]  addr_high, next_addr_high;
	logic [7:0]  status, next_status;
	logic        id_verified, next_id_verified;
	logic        id_match, next_id_match;
	logic        lock_disable, next_lock_disable;
	logic        next_mem_req;
	mem_op_t     next_mem_op;
	logic [15:0] next_mem_page;
	logic [7:0]  next_mem_index, next_mem_wdata;
	logic        tx_load, next_tx_load;
	logic [7:0]  tx_data, next_tx_data;
	logic        sh_start, sh_done;
	logic [7:0]  sh_rx;
	logic        txd;
	logic [15:0] page;
	logic        in_boot, id_ok;
	logic [7:0]  secondary;
	logic [7:0]  id_expect;

	link_shifter u_shifter (
		.clock    (clock),
		.resetn   (resetn),
		.sclk_pin (link.transfer_clock_in),
		.rxd_pin  (link.serial_receive_in),
		.tx_load  (tx_load),
		.tx_data  (tx_data),
		.txd      (txd),
		.start    (sh_start),
		.done     (sh_done),
		.rx_byte  (sh_rx)
	);

	// only four link wires exist
	assign link.serial_transmit_out = txd;
	assign link.busy_indicator_out  = busy;

	// straps are pins: two stages before anything reads them
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_s1 <= 3'b000;
			strap_s2 <= 3'b000;
		end else begin
			strap_s1 <= {processor_mode_strap, program_enable_strap, chip_select_strap};
			strap_s2 <= strap_s1;
		end
	end

	assign byte_no   = idx + 9'd1;
	assign page      = {addr_high, addr_mid};
	assign in_boot   = page >= `BOOT_FIRST_PAGE;
	assign id_ok     = mem_blank | id_verified;
	assign secondary = {6'h00, lock_disable, id_verified};
	// id byte n of the transfer is compared with stored byte n-6
	assign id_expect = stored_id[8 * (byte_no - `BYTE_ID_FIRST) +: 8];

	// command sequencing
	always_comb begin
		next_state        = state;
		next_settle       = settle;
		next_serial_mode  = serial_mode;
		next_busy         = busy;
		next_cmd          = cmd;
		next_idx          = idx;
		next_addr_mid     = addr_mid;
		next_addr_high    = addr_high;
		next_status       = status;
		next_id_verified  = id_verified;
		next_id_match     = id_match;
		next_lock_disable = lock_disable;
		next_mem_req      = mem_req;
		next_mem_op       = mem_op;
		next_mem_page     = mem_page;
		next_mem_index    = mem_index;
		next_mem_wdata    = mem_wdata;
		next_tx_load      = 1'b0;
		next_tx_data      = tx_data;
		case (state)
			DS_STRAP: begin
				// wait for the strap synchronisers to fill after release
				if (settle == `STRAP_SETTLE_CYCLES) begin
					next_serial_mode = strap_s2[0] & ~strap_s2[1] & strap_s2[2];
					next_state       = next_serial_mode ? DS_CMD : DS_OFF;
					next_busy        = ~next_serial_mode;
				end else begin
					next_settle = settle + 3'd1;
				end
			end
			DS_CMD: begin
				if (sh_start) begin
					next_busy = 1'b1;
				end
				if (sh_done) begin
					next_busy = 1'b0;
					next_cmd  = sh_rx;
					next_idx  = 9'd1;
					if (!id_ok && sh_rx != `CMD_READ_STATUS && sh_rx != `CMD_ID_CHECK) begin
						next_state = DS_CMD;
					end else begin
						case (sh_rx)
							`CMD_READ_STATUS: begin
								next_state   = DS_ARG;
								next_tx_load = 1'b1;
								next_tx_data = status;
							end
							`CMD_CLEAR_STATUS: begin
								next_status[`SR_ERASE_ERR_BIT] = 1'b0;
								next_status[`SR_PROG_ERR_BIT]  = 1'b0;
								next_status[`SR_OVERWRITE_BIT] = 1'b0;
							end
							`CMD_LOCK_ENABLE: next_lock_disable = 1'b0;
							`CMD_LOCK_DISABLE: next_lock_disable = 1'b1;
							`CMD_ID_CHECK: begin
								next_state    = DS_ARG;
								next_id_match = 1'b1;
							end
							`CMD_PAGE_READ, `CMD_PAGE_PROG, `CMD_BLOCK_ERASE,
							`CMD_ERASE_ALL, `CMD_READ_LOCK, `CMD_LOCK_PROG: begin
								next_state = DS_ARG;
							end
							default: next_state = DS_CMD;
						endcase
					end
				end
			end
			DS_ARG: begin
				if (sh_start) begin
					next_busy = 1'b1;
				end
				if (sh_done) begin
					next_busy = 1'b0;
					next_idx  = byte_no;
					if (byte_no == `BYTE_ADDR_MID) begin
						next_addr_mid = sh_rx;
					end
					if (byte_no == `BYTE_ADDR_HIGH) begin
						next_addr_high = sh_rx;
					end
					case (cmd)
						`CMD_READ_STATUS: begin
							if (byte_no == 9'd2) begin
								next_tx_load = 1'b1;
								next_tx_data = secondary;
							end else begin
								next_state = DS_CMD;
							end
						end
						`CMD_PAGE_READ: begin
							if (byte_no >= `BYTE_ADDR_HIGH && byte_no < `BYTE_LAST) begin
								next_busy      = 1'b1;
								next_state     = DS_MEM;
								next_mem_req   = 1'b1;
								next_mem_op    = MEM_READ;
								next_mem_page  = {(byte_no == `BYTE_ADDR_HIGH) ? sh_rx : addr_high,
									addr_mid};
								next_mem_index = 8'(byte_no - `BYTE_ADDR_HIGH);
							end else if (byte_no >= `BYTE_LAST) begin
								next_state = DS_CMD;
							end
						end
						`CMD_PAGE_PROG: begin
							if (byte_no >= `BYTE_DATA_FIRST) begin
								next_busy      = 1'b1;
								next_state     = DS_MEM;
								next_mem_req   = 1'b1;
								next_mem_op    = MEM_WRITE;
								next_mem_page  = page;
								next_mem_index = 8'(byte_no - `BYTE_DATA_FIRST);
								next_mem_wdata = sh_rx;
							end
						end
						`CMD_READ_LOCK: begin
							if (byte_no == `BYTE_ADDR_HIGH) begin
								next_busy     = 1'b1;
								next_state    = DS_MEM;
								next_mem_req  = 1'b1;
								next_mem_op   = MEM_LOCK_READ;
								next_mem_page = {sh_rx, addr_mid};
							end else if (byte_no > `BYTE_ADDR_HIGH) begin
								next_state = DS_CMD;
							end
						end
						`CMD_BLOCK_ERASE, `CMD_LOCK_PROG, `CMD_ERASE_ALL: begin
							if ((cmd == `CMD_ERASE_ALL) ? (byte_no == 9'd2)
								: (byte_no == `BYTE_CONFIRM)) begin
								next_state = DS_CMD;
								if (sh_rx == `CMD_CONFIRM) begin
									if (cmd == `CMD_BLOCK_ERASE && in_boot) begin
										next_status[`SR_ERASE_ERR_BIT] = 1'b1;
									end else begin
										next_busy     = 1'b1;
										next_state    = DS_MEM;
										next_mem_req  = 1'b1;
										next_mem_page = page;
										next_status[`SR_READY_BIT] = 1'b0;
										case (cmd)
											`CMD_BLOCK_ERASE: next_mem_op = MEM_ERASE_BLOCK;
											`CMD_ERASE_ALL: next_mem_op = MEM_ERASE_ALL;
											default: next_mem_op = MEM_LOCK_PROG;
										endcase
									end
								end else if (sh_rx != `CMD_CANCEL) begin
									// wrong confirm byte: command sequence error
									next_status[`SR_ERASE_ERR_BIT] = 1'b1;
									next_status[`SR_PROG_ERR_BIT]  = 1'b1;
								end
							end
						end
						`CMD_ID_CHECK: begin
							if (byte_no >= `BYTE_ID_FIRST && sh_rx != id_expect) begin
								next_id_match = 1'b0;
							end
							if (byte_no == `BYTE_ID_LAST) begin
								next_id_verified = id_match && sh_rx == id_expect;
								next_state       = DS_CMD;
							end
						end
						default: next_state = DS_CMD;
					endcase
				end
			end
			DS_MEM: begin
				if (mem_ack) begin
					next_mem_req = 1'b0;
					next_busy    = 1'b0;
					next_state   = DS_ARG;
					case (mem_op)
						MEM_READ: begin
							next_tx_load = 1'b1;
							next_tx_data = mem_rdata;
						end
						MEM_LOCK_READ: begin
							next_tx_load = 1'b1;
							next_tx_data = 8'h00;
							next_tx_data[`LOCK_DATA_BIT] = mem_lock;
						end
						MEM_WRITE: begin
							if (idx >= `BYTE_LAST) begin
								next_state = DS_CMD;
								if (in_boot) begin
									next_status[`SR_PROG_ERR_BIT] = 1'b1;
								end else begin
									// page buffer full: chain straight into the program
									next_busy    = 1'b1;
									next_state   = DS_MEM;
									next_mem_req = 1'b1;
									next_mem_op  = MEM_PROG;
									next_status[`SR_READY_BIT] = 1'b0;
								end
							end
						end
						default: begin
							next_state = DS_CMD;
							next_status[`SR_READY_BIT] = 1'b1;
							if (mem_fail && (mem_op == MEM_ERASE_BLOCK || mem_op == MEM_ERASE_ALL)) begin
								next_status[`SR_ERASE_ERR_BIT] = 1'b1;
							end
							if (mem_fail && (mem_op == MEM_PROG || mem_op == MEM_LOCK_PROG)) begin
								next_status[`SR_PROG_ERR_BIT] = 1'b1;
							end
							if (mem_overwrite && mem_op == MEM_PROG) begin
								next_status[`SR_OVERWRITE_BIT] = 1'b1;
							end
						end
					endcase
				end
			end
			default: next_state = DS_OFF;
		endcase
	end

	// reset returns sequencing to the strap check before any command byte
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state        <= DS_STRAP;
			settle       <= 3'd0;
			serial_mode  <= 1'b0;
			busy         <= 1'b1;
			cmd          <= 8'h00;
			idx          <= 9'd0;
			addr_mid     <= 8'h00;
			addr_high    <= 8'h00;
			status       <= `STATUS_RESET;
			id_verified  <= 1'b0;
			id_match     <= 1'b0;
			lock_disable <= 1'b0;
			mem_req      <= 1'b0;
			mem_op       <= MEM_READ;
			mem_page     <= 16'h0000;
			mem_index    <= 8'h00;
			mem_wdata    <= 8'h00;
			tx_load      <= 1'b0;
			tx_data      <= 8'hff;
		end else begin
			state        <= next_state;
			settle       <= next_settle;
			serial_mode  <= next_serial_mode;
			busy         <= next_busy;
			cmd          <= next_cmd;
			idx          <= next_idx;
			addr_mid     <= next_addr_mid;
			addr_high    <= next_addr_high;
			status       <= next_status;
			id_verified  <= next_id_verified;
			id_match     <= next_id_match;
			lock_disable <= next_lock_disable;
			mem_req      <= next_mem_req;
			mem_op       <= next_mem_op;
			mem_page     <= next_mem_page;
			mem_index    <= next_mem_index;
			mem_wdata    <= next_mem_wdata;
			tx_load      <= next_tx_load;
			tx_data      <= next_tx_data;
		end
	end

	// lock override follows the last lock enable or disable command
	assign mem_unlock_all = lock_disable;
endmodule

/* File: inc/fsb_consts.svh */
// constants for the serial boot command port: command codes, status layout, timing
`ifndef FSB_CONSTS_SVH
`define FSB_CONSTS_SVH

// command codes, first byte of each transfer, except confirm and cancel
`define CMD_PAGE_READ       8'hff
`define CMD_PAGE_PROG       8'h41
`define CMD_BLOCK_ERASE     8'h20
`define CMD_ERASE_ALL       8'ha7
`define CMD_CONFIRM         8'hd0
`define CMD_CANCEL          8'hff
`define CMD_READ_STATUS     8'h70
`define CMD_CLEAR_STATUS    8'h50
`define CMD_READ_LOCK       8'h71
`define CMD_LOCK_PROG       8'h77
`define CMD_LOCK_ENABLE     8'h7a
`define CMD_LOCK_DISABLE    8'h75
`define CMD_ID_CHECK        8'hf5

// primary status byte
`define STATUS_RESET        8'h80
`define SR_READY_BIT        7
`define SR_ERASE_ERR_BIT    5
`define SR_PROG_ERR_BIT     4
`define SR_OVERWRITE_BIT    3
// secondary status byte
`define SEC_ID_VERIFIED_BIT 0
`define SEC_LOCK_DIS_BIT    1
// lock bit position in the lock status byte
`define LOCK_DATA_BIT       6

// byte numbers within a transfer, counted from 1
`define BYTE_ADDR_MID       9'd2
`define BYTE_ADDR_HIGH      9'd3
`define BYTE_CONFIRM        9'd4
`define BYTE_DATA_FIRST     9'd4
`define BYTE_LAST           9'd259
`define BYTE_ID_FIRST       9'd6
`define BYTE_ID_LAST        9'd12
`define ID_BYTES            7

// 8 Kbyte boot area = 32 pages of 256 bytes, top of the page space
`define BOOT_FIRST_PAGE     16'h0fe0

// timing
`define CLOCK_PERIOD_NS     50
`define LINK_PERIOD_NS      400
`define LINK_HALF_CYCLES    ((`LINK_PERIOD_NS / 2) / `CLOCK_PERIOD_NS)
`define STRAP_SETTLE_CYCLES 3'd3

`endif

/* File: inc/fsb_pkg.sv */
// types shared by both ends of the serial boot link
package fsb_pkg;

	typedef enum logic [2:0] {
		MEM_READ        = 3'b000,
		MEM_WRITE       = 3'b001,
		MEM_PROG        = 3'b010,
		MEM_ERASE_BLOCK = 3'b011,
		MEM_ERASE_ALL   = 3'b100,
		MEM_LOCK_READ   = 3'b101,
		MEM_LOCK_PROG   = 3'b110
	} mem_op_t;

	typedef enum logic [2:0] {
		DS_STRAP = 3'b000,
		DS_OFF   = 3'b001,
		DS_CMD   = 3'b010,
		DS_ARG   = 3'b011,
		DS_MEM   = 3'b100
	} dev_state_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WAIT = 2'b01,
		HS_LOW  = 2'b10,
		HS_HIGH = 2'b11
	} host_state_t;

endpackage

/* File: inc/boot_link_if.sv */
// four-wire serial link between programmer and device
`timescale 1ns/1ns
interface boot_link_if;
	logic transfer_clock_in;
	logic serial_receive_in;
	logic serial_transmit_out;
	logic busy_indicator_out;

	modport device (
		input  transfer_clock_in,
		input  serial_receive_in,
		output serial_transmit_out,
		output busy_indicator_out
	);

	modport programmer (
		output transfer_clock_in,
		output serial_receive_in,
		input  serial_transmit_out,
		input  busy_indicator_out
	);
endinterface

/* File: src/link_shifter.sv */
// byte shifter on the sampled transfer clock, with pin synchronisers
`timescale 1ns/1ns
module link_shifter (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       sclk_pin,
	input  wire logic       rxd_pin,
	input  wire logic       tx_load,
	input  wire logic [7:0] tx_data,
	output logic            txd,
	output logic            start,
	output logic            done,
	output logic [7:0]      rx_byte
);
	logic       sclk_s1, sclk_s2, sclk_s3;
	logic       rxd_s1, rxd_s2;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] rx_sh, next_rx_sh;
	logic [7:0] tx_sh, next_tx_sh;
	logic       next_txd, next_start, next_done;
	logic [7:0] next_rx_byte;
	logic       rise, fall;

	// rxd passes the same two stages as the clock so the two stay aligned
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclk_s1 <= 1'b1;
			sclk_s2 <= 1'b1;
			sclk_s3 <= 1'b1;
			rxd_s1  <= 1'b1;
			rxd_s2  <= 1'b1;
		end else begin
			sclk_s1 <= sclk_pin;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			rxd_s1  <= rxd_pin;
			rxd_s2  <= rxd_s1;
		end
	end

	assign rise = sclk_s2 & ~sclk_s3;
	assign fall = ~sclk_s2 & sclk_s3;

	// shift logic, lsb first in both directions
	always_comb begin
		next_bit_cnt = bit_cnt;
		next_rx_sh   = rx_sh;
		next_tx_sh   = tx_sh;
		next_txd     = txd;
		next_start   = 1'b0;
		next_done    = 1'b0;
		next_rx_byte = rx_byte;
		if (fall) begin
			next_txd   = tx_sh[0];
			next_tx_sh = {1'b1, tx_sh[7:1]};
			if (bit_cnt == 4'd0) begin
				next_start = 1'b1;
			end
		end
		if (rise) begin
			next_rx_sh = {rxd_s2, rx_sh[7:1]};
			if (bit_cnt == 4'd7) begin
				next_done    = 1'b1;
				next_rx_byte = {rxd_s2, rx_sh[7:1]};
				next_bit_cnt = 4'd0;
				next_tx_sh   = 8'hff; // idle fill when nothing is loaded
			end else begin
				next_bit_cnt = bit_cnt + 4'd1;
			end
		end
		if (tx_load) begin
			next_tx_sh = tx_data;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bit_cnt <= 4'd0;
			rx_sh   <= 8'h00;
			tx_sh   <= 8'hff;
			txd     <= 1'b1;
			start   <= 1'b0;
			done    <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			bit_cnt <= next_bit_cnt;
			rx_sh   <= next_rx_sh;
			tx_sh   <= next_tx_sh;
			txd     <= next_txd;
			start   <= next_start;
			done    <= next_done;
			rx_byte <= next_rx_byte;
		end
	end
endmodule

/* File: src/boot_port_programmer.sv */
// programmer end: makes the transfer clock and exchanges one byte per request
`timescale 1ns/1ns
`include "fsb_consts.svh"
module boot_port_programmer
	import fsb_pkg::*;
#(
	parameter int HALF_CYCLES = `LINK_HALF_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	boot_link_if.programmer link,
	input  wire logic       xfer_start,
	input  wire logic [7:0] xfer_wdata,
	output logic            xfer_ready,
	output logic [7:0]      xfer_rdata,
	output logic            xfer_done
);
	host_state_t state, next_state;
	logic       busy_s1, busy_s2, txd_s1, txd_s2;
	logic       sclk, next_sclk, rxd, next_rxd;
	logic [7:0] cnt, next_cnt;
	logic [2:0] bits, next_bits;
	logic [7:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
	logic       next_ready, next_done;
	logic [7:0] next_rdata;

	assign link.transfer_clock_in = sclk;
	assign link.serial_receive_in = rxd;

	// device pins cross into this clock through two stages
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busy_s1 <= 1'b1;
			busy_s2 <= 1'b1;
			txd_s1  <= 1'b1;
			txd_s2  <= 1'b1;
		end else begin
			busy_s1 <= link.busy_indicator_out;
			busy_s2 <= busy_s1;
			txd_s1  <= link.serial_transmit_out;
			txd_s2  <= txd_s1;
		end
	end

	// clock divider and bit sequencing
	always_comb begin
		next_state = state;
		next_sclk  = sclk;
		next_rxd   = rxd;
		next_cnt   = cnt;
		next_bits  = bits;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_ready = xfer_ready;
		next_done  = 1'b0;
		next_rdata = xfer_rdata;
		case (state)
			HS_IDLE: begin
				if (xfer_start) begin
					next_state = HS_WAIT;
					next_ready = 1'b0;
					next_tx_sh = xfer_wdata;
					next_bits  = 3'd0;
				end
			end
			HS_WAIT: begin
				if (!busy_s2) begin
					next_state = HS_LOW;
					next_sclk  = 1'b0;
					next_rxd   = tx_sh[0];
					next_tx_sh = {1'b1, tx_sh[7:1]};
					next_cnt   = 8'(HALF_CYCLES - 1);
				end
			end
			HS_LOW: begin
				if (cnt == 8'd0) begin
					next_state = HS_HIGH;
					next_sclk  = 1'b1;
					next_cnt   = 8'(HALF_CYCLES - 1);
				end else begin
					next_cnt = cnt - 8'd1;
				end
			end
			HS_HIGH: begin
				if (cnt == 8'd0) begin
					// late in the high phase the device bit has long settled
					next_rx_sh = {txd_s2, rx_sh[7:1]};
					if (bits == 3'd7) begin
						next_state = HS_IDLE;
						next_ready = 1'b1;
						next_done  = 1'b1;
						next_rdata = {txd_s2, rx_sh[7:1]};
					end else begin
						next_state = HS_LOW;
						next_bits  = bits + 3'd1;
						next_sclk  = 1'b0;
						next_rxd   = tx_sh[0];
						next_tx_sh = {1'b1, tx_sh[7:1]};
						next_cnt   = 8'(HALF_CYCLES - 1);
					end
				end else begin
					next_cnt = cnt - 8'd1;
				end
			end
			default: next_state = HS_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state      <= HS_IDLE;
			sclk       <= 1'b1;
			rxd        <= 1'b1;
			cnt        <= 8'h00;
			bits       <= 3'd0;
			tx_sh      <= 8'hff;
			rx_sh      <= 8'h00;
			xfer_ready <= 1'b1;
			xfer_done  <= 1'b0;
			xfer_rdata <= 8'h00;
		end else begin
			state      <= next_state;
			sclk       <= next_sclk;
			rxd        <= next_rxd;
			cnt        <= next_cnt;
			bits       <= next_bits;
			tx_sh      <= next_tx_sh;
			rx_sh      <= next_rx_sh;
			xfer_ready <= next_ready;
			xfer_done  <= next_done;
			xfer_rdata <= next_rdata;
		end
	end
endmodule

/* File: dv/boot_link_props.sv */
// link protocol checker for the serial boot port
`timescale 1ns/1ns
module boot_link_props (
	input wire logic clock,
	input wire logic resetn,
	input wire logic transfer_clock_in,
	input wire logic serial_receive_in,
	input wire logic serial_transmit_out,
	input wire logic busy_indicator_out
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// busy guards every byte and the memory work behind it
	a_busy_rise: assert property ($fell(transfer_clock_in) |-> ##[1:4] busy_indicator_out)
		else $error("busy missed a byte start");
	a_busy_hold: assert property ($rose(transfer_clock_in) |=> busy_indicator_out)
		else $error("busy low inside a byte");
	a_reset_busy: assert property ($rose(resetn) |-> busy_indicator_out[*4])
		else $error("busy low during strap settle");
	// programmer needs its synchroniser delay before a new byte
	a_wait_busy: assert property ($fell(busy_indicator_out) |-> transfer_clock_in[*3])
		else $error("byte started too soon");
	a_clk_low: assert property ($fell(transfer_clock_in) |-> !transfer_clock_in[*4] ##1
		transfer_clock_in)
		else $error("link clock low phase wrong");
	a_clk_high: assert property ($rose(transfer_clock_in) |-> transfer_clock_in[*4])
		else $error("link clock high phase short");
	// data lines only move around the falling edge
	a_tx_hold: assert property ($rose(transfer_clock_in) |=> $stable(serial_transmit_out)[*3])
		else $error("transmit moved near rise");
	a_rx_hold: assert property ($rose(transfer_clock_in) |=> $stable(serial_receive_in)[*3])
		else $error("receive moved near rise");

	c_byte: cover property ($fell(busy_indicator_out));
	c_rise: cover property ($rose(transfer_clock_in));
	c_tx: cover property ($fell(serial_transmit_out));
endmodule

/* File: dv/tb_flash_serial_boot_command_port.sv */
// self-checking bench: programmer end talks to device end over the link
`timescale 1ns/1ns
module tb_flash_serial_boot_command_port
	import fsb_pkg::*;
;
	logic clock = 1'b0;
	logic resetn, cs, pe, md, xfer_start, xfer_ready, xfer_done;
	logic mem_ack, mem_lock, serial_mode, mem_req, mem_unlock_all;
	logic [7:0] xfer_wdata, xfer_rdata, mem_rdata, mem_index, mem_wdata, rnd = 8'h18;
	logic [7:0] wq [256];
	logic [7:0] exp_d [256];
	logic [15:0] mem_page, last_page;
	logic [31:0] rv;
	mem_op_t mem_op, last_op;
	int mismatches = 0, n_tests = 0, n_ops = 0, n;

	always #25 clock = ~clock;
	boot_link_if lnk ();
	boot_port_device i_boot_port_device (.clock(clock), .resetn(resetn), .link(lnk),
		.chip_select_strap(cs), .program_enable_strap(pe), .processor_mode_strap(md),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_lock(mem_lock), .mem_fail(1'b0),
		.mem_overwrite(1'b0), .mem_blank(1'b0), .stored_id(56'h77_6655_4433_2211),
		.serial_mode(serial_mode), .mem_req(mem_req), .mem_op(mem_op), .mem_page(mem_page),
		.mem_index(mem_index), .mem_wdata(mem_wdata), .mem_unlock_all(mem_unlock_all));
	boot_port_programmer i_boot_port_programmer (.clock(clock), .resetn(resetn), .link(lnk),
		.xfer_start(xfer_start), .xfer_wdata(xfer_wdata), .xfer_ready(xfer_ready),
		.xfer_rdata(xfer_rdata), .xfer_done(xfer_done));
	boot_link_props i_boot_link_props (.clock(clock), .resetn(resetn),
		.transfer_clock_in(lnk.transfer_clock_in), .serial_receive_in(lnk.serial_receive_in),
		.serial_transmit_out(lnk.serial_transmit_out),
		.busy_indicator_out(lnk.busy_indicator_out));

	function logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// flash model: random ack delay, data derived from page and index
	always @(negedge clock) begin
		rnd = nx(rnd);
		mem_ack <= mem_req & ~mem_ack & rnd[0];
		mem_rdata <= mem_index ^ mem_page[7:0];
		mem_lock <= mem_page[0];
	end
	always @(posedge clock) if (mem_req && mem_ack) begin
		n_ops++;
		last_op = mem_op;
		last_page = mem_page;
		if (mem_op == MEM_WRITE) wq[mem_index] = mem_wdata;
	end

	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task end_sim;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task rst(input logic [2:0] s);
		resetn = 1'b0;
		{cs, pe, md} = s;
		repeat (16) @(negedge clock);
		resetn = 1'b1;
		repeat (8) @(negedge clock);
	endtask
	// k bytes of v, low byte first; bytes read back land in rv
	task seq(input int k, input logic [31:0] v);
		for (int i = 0; i < k; i++) begin
			xfer_wdata = v[8*(i%4) +: 8];
			xfer_start = 1'b1;
			@(negedge clock);
			xfer_start = 1'b0;
			// a hung byte is left to the watchdog, which fails the run
			while (xfer_done !== 1'b1) @(negedge clock);
			rv[8*(i%4) +: 8] = xfer_rdata;
		end
	endtask
	task st(input logic [15:0] e);
		seq(3, 32'h70);
		chk("status", e, rv[23:8]);
		chk("ready", 1, xfer_ready);
	endtask

	initial begin
		#3000000;
		mismatches++;
		end_sim;
	end
	initial begin
		{xfer_start, xfer_wdata} = '0;
		rst(3'b111);
		chk("busy", 1, lnk.busy_indicator_out);
		chk("off", 0, serial_mode);
		rst(3'b101);
		chk("mode", 1, serial_mode);
		st(16'h0080);
		seq(4, 32'h0012ff);
		chk("locked", 8'hff, rv[31:24]);
		chk("ops", 0, 16'(n_ops));
		for (int p = 0; p < 2; p++) begin
			seq(4, 32'hf5);
			seq(1, 32'h07);
			for (int k = 0; k < 7; k++) seq(1, {24'h0, 8'(k * 8'h11 + 8'h11 + p - 1)});
			st({7'h0, p[0], 8'h80});
		end
		seq(1, 32'h75);
		st(16'h0380);
		chk("unlock", 1, mem_unlock_all);
		seq(1, 32'h7a);
		st(16'h0180);
		chk("unlock", 0, mem_unlock_all);
		seq(3, 32'h0012ff);
		for (int i = 0; i < 256; i++) begin
			seq(1, 32'h0);
			chk("read data", {8'h0, 8'(i) ^ 8'h12}, {8'h0, rv[7:0]});
		end
		chk("read page", 16'h0012, last_page);
		seq(3, 32'h003441);
		for (int i = 0; i < 256; i++) begin
			exp_d[i] = rnd;
			seq(1, {24'h0, exp_d[i]});
		end
		st(16'h0180);
		chk("prog op", 16'(MEM_PROG), 16'(last_op));
		chk("prog page", 16'h0034, last_page);
		for (int i = 0; i < 256; i++) chk("prog data", {8'h0, exp_d[i]}, {8'h0, wq[i]});
		seq(4, 32'hd0000e20);
		st(16'h0180);
		chk("erase op", 16'(MEM_ERASE_BLOCK), 16'(last_op));
		chk("erase page", 16'h000e, last_page);
		n = n_ops;
		seq(4, 32'hd00fe020);
		st(16'h01a0);
		seq(1, 32'h50);
		chk("boot ops", 16'(n), 16'(n_ops));
		seq(4, 32'h33000e20);
		st(16'h01b0);
		seq(1, 32'h50);
		st(16'h0180);
		seq(2, 32'hd0a7);
		st(16'h0180);
		chk("all op", 16'(MEM_ERASE_ALL), 16'(last_op));
		seq(4, 32'hd0000e77);
		st(16'h0180);
		chk("lock op", 16'(MEM_LOCK_PROG), 16'(last_op));
		seq(4, 32'h000f71);
		chk("lock bit", 8'h40, rv[31:24]);
		n = n_ops;
		seq(1, 32'h13);
		st(16'h0180);
		chk("stray ops", 16'(n), 16'(n_ops));
		rst(3'b101);
		st(16'h0080);
		end_sim;
	end
endmodule
